// [src/amed_pkg.sv]
/*
  Shared constants and carrier types for the motion event detector.
  Assumes one 125 MHz clock and samples delivered synchronously with a one-cycle ready strobe.
*/
// How it works
// - Detectors evaluate once per accelerometer sample.
// - No motion events in synchronized sampling mode.
// - Slope is current sample minus previous sample.
// - Any-motion: slope above threshold for window.
// - Slope inside threshold band clears any-motion.
// - No-motion: slope below threshold for window.
// - Slope outside threshold band clears no-motion.
// - Detection sets flag, drives selected interrupt pin.
// - Second any-motion between wait and confirm.
// - No-motion detection clears significant-motion flag; a confirmation in the same sample wins.
// - Combine bit: zero OR, one AND.
// - Per-axis enables include or exclude axes.
// - Thresholds unsigned eight bits, LSB 1/32 g.
// - Windows eight bits; significant windows sixteen bits.
// - Mode byte holds combine bits and enables.
// - Engine enable bits, gated by accelerometer enable.
// - Routing bit selects first or second pin.
// - Status bits 7:5 report detected events.
package amed_pkg;
  localparam int ACC_W = 16;
  localparam int THR_W = 8;
  localparam int DUR_W = 8;
  localparam int SIG_W = 16;
  localparam int CAL_BYTES = 7;

  localparam logic [7:0] CMD_CONFIGURE_MOTION = 8'h0E;
  localparam logic [3:0] CMD_SET_FIRST = 4'h1;
  localparam logic [3:0] CMD_SET_SECOND = 4'h2;
  localparam int CMD_TAG_LSB = 4;

  localparam int MODE_STILL_COMB = 7;
  localparam int MODE_STILL_EN_LSB = 4;
  localparam int MODE_MOVE_COMB = 3;
  localparam int MODE_MOVE_EN_LSB = 0;

  localparam int ENG_MOVE = 1;
  localparam int ENG_STILL = 2;
  localparam int ENG_SIG = 3;
  localparam int ENG_ROUTE_FIRST = 6;

  localparam int STAT_MOVE = 5;
  localparam int STAT_STILL = 6;
  localparam int STAT_SIG = 7;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [THR_W-1:0] THR_RST = 8'h00;
  localparam logic [DUR_W-1:0] DUR_RST = 8'h00;
  localparam logic [SIG_W-1:0] SIG_WIN_RST = 16'h0000;
  localparam logic [DUR_W-1:0] DUR_MAX = 8'hFF;
  localparam logic [SIG_W-1:0] SIG_MAX = 16'hFFFF;

  typedef struct packed {
    logic [2:0][ACC_W-1:0] acc;
  } amed_sample_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] tag;
    logic [CAL_BYTES-1:0][7:0] cal;
  } amed_cmd_t;
endpackage

// [src/amed_axis.sv]
/*
  One accelerometer axis: slope and the two consecutive-sample window counters.
  Assumes the strobe marks a new sample on the acc input for exactly one cycle.
*/
`timescale 1ns/100ps
module amed_axis (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sample_stb,
  input wire logic move_run,
  input wire logic still_run,
  input wire logic [amed_pkg::ACC_W-1:0] acc,
  input wire logic [amed_pkg::THR_W-1:0] move_thr,
  input wire logic [amed_pkg::THR_W-1:0] still_thr,
  input wire logic [amed_pkg::DUR_W-1:0] move_dur,
  input wire logic [amed_pkg::DUR_W-1:0] still_dur,
  output logic move_hit,
  output logic still_hit
);
  import amed_pkg::*;
  logic [ACC_W-1:0] prev_ff;
  logic have_ff;
  logic [DUR_W-1:0] move_cnt_ff, nxt_move_cnt;
  logic [DUR_W-1:0] still_cnt_ff, nxt_still_cnt;
  logic signed [ACC_W:0] slope;
  logic [ACC_W:0] mag;
  logic above, below;

  always_comb begin
    slope = $signed({acc[ACC_W-1], acc}) - $signed({prev_ff[ACC_W-1], prev_ff});
    mag = slope[ACC_W] ? $unsigned(-slope) : $unsigned(slope);
    above = have_ff && (mag > {{(ACC_W+1-THR_W){1'b0}}, move_thr});
    below = have_ff && (mag < {{(ACC_W+1-THR_W){1'b0}}, still_thr});
    nxt_move_cnt = !above ? DUR_RST : (move_cnt_ff == DUR_MAX ? DUR_MAX : move_cnt_ff + 8'h01);
    nxt_still_cnt = !below ? DUR_RST : (still_cnt_ff == DUR_MAX ? DUR_MAX : still_cnt_ff + 8'h01);
    move_hit = above && (nxt_move_cnt >= move_dur);
    still_hit = below && (nxt_still_cnt >= still_dur);
  end

  // The previous sample is tracked even with engines off so the first slope after enabling is real.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_ff <= 16'h0000;
      have_ff <= 1'b0;
    end else if (sample_stb) begin
      prev_ff <= acc;
      have_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !move_run) begin
      move_cnt_ff <= DUR_RST;
    end else if (sample_stb) begin
      move_cnt_ff <= nxt_move_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !still_run) begin
      still_cnt_ff <= DUR_RST;
    end else if (sample_stb) begin
      still_cnt_ff <= nxt_still_cnt;
    end
  end

  AST_RUN_RESTART: assert property (@(posedge clk) disable iff (!rstn)
    sample_stb && move_run && !above |=> move_cnt_ff == DUR_RST)
    else $error("Any-motion run counter did not restart.");
endmodule

// [src/amed_sig.sv]
/*
  Significant-motion sequencer counting samples from a first any-motion event.
  Assumes move_rise and still_det are qualified by the sample strobe.
*/
`timescale 1ns/100ps
module amed_sig (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sample_stb,
  input wire logic run,
  input wire logic move_rise,
  input wire logic still_det,
  input wire logic [amed_pkg::SIG_W-1:0] wait_win,
  input wire logic [amed_pkg::SIG_W-1:0] confirm_win,
  output logic sig_flag
);
  import amed_pkg::*;
  typedef enum logic [0:0] {
    AMED_SIG_IDLE = 1'b0,
    AMED_SIG_ARMED = 1'b1
  } amed_sig_state_t;

  amed_sig_state_t state_ff;
  logic [SIG_W-1:0] cnt_ff, nxt_cnt;
  logic confirm, expire;

  always_comb begin
    nxt_cnt = (cnt_ff == SIG_MAX) ? SIG_MAX : cnt_ff + 16'h0001;
    confirm = (state_ff == AMED_SIG_ARMED) && move_rise && (nxt_cnt > wait_win) && (nxt_cnt <= confirm_win);
    expire = nxt_cnt >= confirm_win;
  end

  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      state_ff <= AMED_SIG_IDLE;
      cnt_ff <= SIG_WIN_RST;
    end else if (sample_stb) begin
      case (state_ff)
        AMED_SIG_IDLE: begin
          if (move_rise) begin
            state_ff <= AMED_SIG_ARMED;
            cnt_ff <= SIG_WIN_RST;
          end
        end
        AMED_SIG_ARMED: begin
          cnt_ff <= nxt_cnt;
          if (confirm || expire) begin
            state_ff <= AMED_SIG_IDLE;
          end
        end
        default: begin
          state_ff <= AMED_SIG_IDLE;
        end
      endcase
    end
  end

  // A confirmation in the same sample as a no-motion detection keeps the flag set.
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      sig_flag <= 1'b0;
    end else if (sample_stb && confirm) begin
      sig_flag <= 1'b1;
    end else if (sample_stb && still_det) begin
      sig_flag <= 1'b0;
    end
  end

  AST_SIG_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    sample_stb && still_det && !confirm |=> !sig_flag)
    else $error("Significant-motion flag survived a no-motion detection.");

  AST_SIG_EARLY: assert property (@(posedge clk) disable iff (!rstn)
    sample_stb && run && !sig_flag && state_ff == AMED_SIG_ARMED && nxt_cnt <= wait_win |=> !sig_flag)
    else $error("Significant motion raised inside the wait window.");
endmodule

// [src/amed_top.sv]
/*
  Motion event detector: configuration command intake, three axis slope units,
  axis combining, event flags, status byte and interrupt pin routing.
  Assumes samples, command strobe and control levels are synchronous to CLK.
*/
`timescale 1ns/100ps
module amed_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SAMPLE_READY_STROBE,
  input wire amed_pkg::amed_sample_t SAMPLE,
  input wire logic ACCEL_ON,
  input wire logic FREE_RUNNING_SAMPLING,
  input wire logic [7:0] ENGINE_ENABLE_REG,
  input wire logic CMD_VALID,
  input wire amed_pkg::amed_cmd_t CMD,
  output logic [7:0] MOTION_AXIS_SELECT_BYTE,
  output logic [7:0] EVENT_STATUS_REG,
  output logic IRQ_PIN_FIRST,
  output logic IRQ_PIN_SECOND
);
  import amed_pkg::*;

  logic [7:0] mode_ff;
  logic [2:0][THR_W-1:0] move_thr_ff, still_thr_ff;
  logic [DUR_W-1:0] move_dur_ff, still_dur_ff;
  logic [SIG_W-1:0] wait_ff, confirm_ff;
  logic take_first, take_second;

  logic active, run_move, run_still, run_sig, route_first;
  logic [2:0] move_en, still_en, move_hit, still_hit;
  logic move_and, still_and;
  logic move_det, still_det, move_rise;
  logic move_ff, still_ff, sig_flag;
  logic stb_d_ff;
  logic motion_evt;
  logic [7:0] status_ff;
  logic irq_first_ff, irq_second_ff;

  // Decode of the two-part parameter load.
  always_comb begin
    take_first = CMD_VALID && CMD.code == CMD_CONFIGURE_MOTION &&
      CMD.tag[7:CMD_TAG_LSB] == CMD_SET_FIRST;
    take_second = CMD_VALID && CMD.code == CMD_CONFIGURE_MOTION &&
      CMD.tag[7:CMD_TAG_LSB] == CMD_SET_SECOND;
  end

  // First set: thresholds in bytes 0..5, mode byte in byte 6.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      move_thr_ff <= {3{THR_RST}};
      still_thr_ff <= {3{THR_RST}};
      mode_ff <= MODE_RST;
    end else if (take_first) begin
      move_thr_ff <= {CMD.cal[2], CMD.cal[1], CMD.cal[0]};
      still_thr_ff <= {CMD.cal[5], CMD.cal[4], CMD.cal[3]};
      mode_ff <= CMD.cal[6];
    end
  end

  // Second set: the two short windows then the two 16-bit windows, low byte first.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      move_dur_ff <= DUR_RST;
      still_dur_ff <= DUR_RST;
      wait_ff <= SIG_WIN_RST;
      confirm_ff <= SIG_WIN_RST;
    end else if (take_second) begin
      move_dur_ff <= CMD.cal[0];
      still_dur_ff <= CMD.cal[1];
      wait_ff <= {CMD.cal[3], CMD.cal[2]};
      confirm_ff <= {CMD.cal[5], CMD.cal[4]};
    end
  end

  assign MOTION_AXIS_SELECT_BYTE = mode_ff;

  // Engines run only with the accelerometer on and outside synchronized sampling.
  always_comb begin
    active = ACCEL_ON && FREE_RUNNING_SAMPLING;
    run_move = active && ENGINE_ENABLE_REG[ENG_MOVE];
    run_still = active && ENGINE_ENABLE_REG[ENG_STILL];
    // Significant motion leans on both other engines; keeping them enabled is left to the host.
    run_sig = active && ENGINE_ENABLE_REG[ENG_SIG];
    route_first = ENGINE_ENABLE_REG[ENG_ROUTE_FIRST];
    move_en = mode_ff[MODE_MOVE_EN_LSB +: 3];
    still_en = mode_ff[MODE_STILL_EN_LSB +: 3];
    move_and = mode_ff[MODE_MOVE_COMB];
    still_and = mode_ff[MODE_STILL_COMB];
  end

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      amed_axis u_axis (
        .clk(CLK),
        .rstn(RSTN),
        .sample_stb(SAMPLE_READY_STROBE),
        .move_run(run_move && move_en[ax]),
        .still_run(run_still && still_en[ax]),
        .acc(SAMPLE.acc[ax]),
        .move_thr(move_thr_ff[ax]),
        .still_thr(still_thr_ff[ax]),
        .move_dur(move_dur_ff),
        .still_dur(still_dur_ff),
        .move_hit(move_hit[ax]),
        .still_hit(still_hit[ax])
      );
    end
  endgenerate

  // An axis set with nothing enabled never reports an event.
  function automatic logic amed_combine(input logic [2:0] hit, input logic [2:0] en, input logic all_mode);
    logic res;
    res = 1'b0;
    if (en != 3'b000) begin
      res = all_mode ? &(hit | ~en) : |(hit & en);
    end
    return res;
  endfunction

  always_comb begin
    move_det = run_move && amed_combine(move_hit, move_en, move_and);
    still_det = run_still && amed_combine(still_hit, still_en, still_and);
    move_rise = SAMPLE_READY_STROBE && move_det && !move_ff;
  end

  // Flags follow the detectors once per sample; a failing sample drops them.
  always_ff @(posedge CLK) begin
    if (!RSTN || !run_move) begin
      move_ff <= 1'b0;
    end else if (SAMPLE_READY_STROBE) begin
      move_ff <= move_det;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN || !run_still) begin
      still_ff <= 1'b0;
    end else if (SAMPLE_READY_STROBE) begin
      still_ff <= still_det;
    end
  end

  amed_sig u_sig (
    .clk(CLK),
    .rstn(RSTN),
    .sample_stb(SAMPLE_READY_STROBE),
    .run(run_sig),
    .move_rise(move_rise),
    .still_det(SAMPLE_READY_STROBE && still_det),
    .wait_win(wait_ff),
    .confirm_win(confirm_ff),
    .sig_flag(sig_flag)
  );

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      stb_d_ff <= 1'b0;
    end else begin
      stb_d_ff <= SAMPLE_READY_STROBE;
    end
  end

  assign motion_evt = move_ff || still_ff || sig_flag;

  // Pins and status move together, one cycle after each sample's flags settle.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      status_ff <= 8'h00;
    end else if (stb_d_ff) begin
      status_ff <= 8'h00;
      status_ff[STAT_MOVE] <= move_ff;
      status_ff[STAT_STILL] <= still_ff;
      status_ff[STAT_SIG] <= sig_flag;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      irq_first_ff <= 1'b0;
      irq_second_ff <= 1'b0;
    end else if (stb_d_ff) begin
      irq_first_ff <= motion_evt && route_first;
      irq_second_ff <= motion_evt && !route_first;
    end
  end

  assign EVENT_STATUS_REG = status_ff;
  assign IRQ_PIN_FIRST = irq_first_ff;
  assign IRQ_PIN_SECOND = irq_second_ff;

  AST_SYNC_QUIET: assert property (@(posedge CLK) disable iff (!RSTN)
    !FREE_RUNNING_SAMPLING |=> !move_ff && !still_ff && !sig_flag)
    else $error("Motion flag set while in synchronized sampling.");

  AST_ENGINE_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    !ENGINE_ENABLE_REG[ENG_MOVE] |=> !move_ff)
    else $error("Any-motion flag set with its engine disabled.");

  AST_SAMPLE_PACED: assert property (@(posedge CLK) disable iff (!RSTN)
    !SAMPLE_READY_STROBE && run_move |=> move_ff == $past(move_ff))
    else $error("Any-motion flag changed between samples.");

  AST_AND_MODE: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && move_and && (move_hit | ~move_en) != 3'h7 |=> !move_ff)
    else $error("AND combining raised any-motion without all axes.");

  AST_OR_MODE: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && run_move && !move_and && |(move_hit & move_en) |=> move_ff)
    else $error("OR combining missed an axis event.");

  AST_NO_AXIS: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && still_en == 3'b000 |=> !still_ff)
    else $error("No-motion raised with no axis enabled.");

  AST_MODE_LOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    take_first |=> mode_ff == $past(CMD.cal[6]))
    else $error("Mode byte not taken from the first parameter set.");

  AST_STATUS_SYNC: assert property (@(posedge CLK) disable iff (!RSTN)
    stb_d_ff |=> EVENT_STATUS_REG[STAT_MOVE] == $past(move_ff) && EVENT_STATUS_REG[STAT_SIG] == $past(sig_flag))
    else $error("Status bits did not follow the flags.");

  AST_ROUTE: assert property (@(posedge CLK) disable iff (!RSTN)
    stb_d_ff && motion_evt |=> (IRQ_PIN_FIRST == $past(route_first)) && (IRQ_PIN_SECOND != $past(route_first)))
    else $error("Motion event routed to the wrong pin.");

  AST_STILL_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    !ENGINE_ENABLE_REG[ENG_STILL] |=> !still_ff)
    else $error("No-motion flag set with its engine disabled.");

  AST_SIG_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    !ENGINE_ENABLE_REG[ENG_SIG] |=> !sig_flag)
    else $error("Significant-motion flag set with its engine disabled.");

  AST_ACCEL_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    !ACCEL_ON |=> !move_ff && !still_ff && !sig_flag)
    else $error("Motion flag set with the accelerometer off.");

  AST_STILL_PACED: assert property (@(posedge CLK) disable iff (!RSTN)
    !SAMPLE_READY_STROBE && run_still |=> still_ff == $past(still_ff))
    else $error("No-motion flag changed between samples.");

  AST_STILL_AND: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && still_and && (still_hit | ~still_en) != 3'h7 |=> !still_ff)
    else $error("AND combining raised no-motion without all axes.");

  AST_STILL_OR: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && run_still && !still_and && |(still_hit & still_en) |=> still_ff)
    else $error("OR combining missed a no-motion axis event.");

  AST_MOVE_NO_AXIS: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && move_en == 3'h0 |=> !move_ff)
    else $error("Any-motion raised with no axis enabled.");

  AST_MOVE_DROP: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && (move_hit & move_en) == 3'h0 |=> !move_ff)
    else $error("Any-motion flag kept with no axis above threshold.");

  AST_STILL_DROP: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && (still_hit & still_en) == 3'h0 |=> !still_ff)
    else $error("No-motion flag kept with no axis below threshold.");

  AST_MOVE_RISE: assert property (@(posedge CLK) disable iff (!RSTN)
    move_rise |=> move_ff)
    else $error("Any-motion detection did not set its flag.");

  AST_THR_LOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    take_first |=> move_thr_ff[0] == $past(CMD.cal[0]) && still_thr_ff[2] == $past(CMD.cal[5]))
    else $error("Thresholds not taken from the first parameter set.");

  AST_WIN_LOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    take_second |=> move_dur_ff == $past(CMD.cal[0]) && still_dur_ff == $past(CMD.cal[1]))
    else $error("Short windows not taken from the second parameter set.");

  AST_WAIT_LOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    take_second |=> wait_ff[15:8] == $past(CMD.cal[3]) && wait_ff[7:0] == $past(CMD.cal[2]))
    else $error("Wait window not taken from the second parameter set.");

  AST_CONFIRM_LOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    take_second |=> confirm_ff[15:8] == $past(CMD.cal[5]) && confirm_ff[7:0] == $past(CMD.cal[4]))
    else $error("Confirm window not taken from the second parameter set.");

  AST_MODE_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    !take_first |=> mode_ff == $past(mode_ff))
    else $error("Mode byte changed without a first parameter set.");

  AST_STATUS_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    !stb_d_ff |=> EVENT_STATUS_REG == $past(EVENT_STATUS_REG))
    else $error("Status byte changed between sample updates.");

  AST_STILL_STATUS: assert property (@(posedge CLK) disable iff (!RSTN)
    stb_d_ff |=> EVENT_STATUS_REG[STAT_STILL] == $past(still_ff))
    else $error("No-motion status bit did not follow its flag.");

  AST_PIN_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    !stb_d_ff |=> IRQ_PIN_FIRST == $past(IRQ_PIN_FIRST) && IRQ_PIN_SECOND == $past(IRQ_PIN_SECOND))
    else $error("Interrupt pin changed between sample updates.");

  AST_PIN_IDLE: assert property (@(posedge CLK) disable iff (!RSTN)
    stb_d_ff && !motion_evt |=> !IRQ_PIN_FIRST && !IRQ_PIN_SECOND)
    else $error("Interrupt pin high with no motion event.");

  AST_PIN_EXCL: assert property (@(posedge CLK) disable iff (!RSTN)
    IRQ_PIN_FIRST |-> !IRQ_PIN_SECOND)
    else $error("Motion event drove both interrupt pins.");

  AST_SIG_NEEDS_MOVE: assert property (@(posedge CLK) disable iff (!RSTN)
    !move_rise && !sig_flag |=> !sig_flag)
    else $error("Significant motion raised without a further any-motion.");

  AST_SIG_STILL_CLEAR: assert property (@(posedge CLK) disable iff (!RSTN)
    SAMPLE_READY_STROBE && still_det && !move_rise |=> !sig_flag)
    else $error("Significant-motion flag kept after a no-motion detection.");
endmodule

// [bench/amed_host_model.sv]
/*
  Host processor model: issues motion configuration commands and feeds accelerometer samples.
  Assumes the engine takes commands and samples on the rising clock edge where their strobe is high.
*/
`timescale 1ns/100ps
module amed_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output amed_pkg::amed_cmd_t cmd,
  output logic sample_ready_strobe,
  output amed_pkg::amed_sample_t sample
);
  import amed_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    sample_ready_strobe = 1'b0;
    sample = '0;
  end

  // Operands are inverted on release so the engine never sees a stale copy that happens to look valid.
  task automatic send_cmd(input logic [7:0] code, input logic [3:0] set, input logic [CAL_BYTES*8-1:0] cal);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd.code = code;
    cmd.tag = {set, 4'h0};
    cmd.cal = cal;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd.cal = ~cal;
  endtask

  // The two idle cycles keep strobes apart and let status and pins settle before the caller looks.
  task automatic send_sample(input logic [ACC_W-1:0] x, input logic [ACC_W-1:0] y, input logic [ACC_W-1:0] z);
    @(posedge clk);
    #1;
    sample_ready_strobe = 1'b1;
    sample.acc[0] = x;
    sample.acc[1] = y;
    sample.acc[2] = z;
    @(posedge clk);
    #1;
    sample_ready_strobe = 1'b0;
    sample.acc = ~sample.acc;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// [bench/amed_tb_top.sv]
/*
  Self-checking bench for the motion event detector, one task per scenario.
  Assumes the host model in the same folder and a 125 MHz clock.
*/
`timescale 1ns/100ps
module amed_tb_top;
  import amed_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic accel_on = 1'b1;
  logic free_run = 1'b1;
  logic [7:0] eng = 8'h00;
  logic cmd_valid;
  amed_cmd_t cmd;
  logic stb;
  amed_sample_t sample;
  logic [7:0] mode_byte;
  logic [7:0] status;
  logic pin1;
  logic pin2;
  logic [ACC_W-1:0] ax = '0;
  logic [ACC_W-1:0] ay = '0;
  int err_count = 0;
  int checks_done = 0;

  always #4 clk = ~clk;

  amed_host_model amed_host_model_i (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .sample_ready_strobe(stb), .sample(sample));

  amed_top amed_top_i (.CLK(clk), .RSTN(rstn), .SAMPLE_READY_STROBE(stb), .SAMPLE(sample),
    .ACCEL_ON(accel_on), .FREE_RUNNING_SAMPLING(free_run), .ENGINE_ENABLE_REG(eng),
    .CMD_VALID(cmd_valid), .CMD(cmd), .MOTION_AXIS_SELECT_BYTE(mode_byte),
    .EVENT_STATUS_REG(status), .IRQ_PIN_FIRST(pin1), .IRQ_PIN_SECOND(pin2));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cfg1(input logic [7:0] mthr, input logic [7:0] sthr, input logic [7:0] mode);
    amed_host_model_i.send_cmd(CMD_CONFIGURE_MOTION, CMD_SET_FIRST, {mode, {3{sthr}}, {3{mthr}}});
  endtask

  task automatic cfg2(input logic [7:0] mw, input logic [7:0] sw, input logic [15:0] wt, input logic [15:0] cf);
    amed_host_model_i.send_cmd(CMD_CONFIGURE_MOTION, CMD_SET_SECOND, {8'h00, cf, wt, sw, mw});
  endtask

  // Moves the tracked acceleration by the given slope, sends it and checks the settled status.
  task automatic step(input logic [15:0] dx, input logic [15:0] dy, input logic [7:0] exp);
    ax = ax + dx;
    ay = ay + dy;
    amed_host_model_i.send_sample(ax, ay, 16'h0000);
    chk8(status, exp);
  endtask

  task automatic s_reset();
    chk8(status, 8'h00);
    chk8(mode_byte, MODE_RST);
    chk1(pin1 | pin2, 1'b0);
  endtask

  task automatic s_config();
    amed_host_model_i.send_cmd(8'h33, CMD_SET_FIRST, {8'hA5, 48'h0});
    chk8(mode_byte, 8'h00);
    cfg1(8'h04, 8'h02, 8'hA5);
    chk8(mode_byte, 8'hA5);
    amed_host_model_i.send_cmd(CMD_CONFIGURE_MOTION, 4'h3, {8'h5A, 48'h0});
    chk8(mode_byte, 8'hA5);
  endtask

  task automatic s_any();
    cfg1(8'h04, 8'h02, 8'h01);
    cfg2(8'h02, 8'h20, 16'h0003, 16'h000A);
    eng = 8'h42;
    amed_host_model_i.send_sample(ax, ay, 16'h0000);
    step(16'd10, 16'd0, 8'h00);
    step(16'd4, 16'd0, 8'h00);
    step(16'hFFF6, 16'd0, 8'h00);
    step(16'd10, 16'd0, 8'h20);
    chk1(pin1, 1'b1);
    chk1(pin2, 1'b0);
    step(16'd4, 16'd0, 8'h00);
    chk1(pin1, 1'b0);
    step(16'd0, 16'd50, 8'h00);
    step(16'd0, 16'hFFCE, 8'h00);
  endtask

  task automatic s_and();
    cfg1(8'h04, 8'h02, 8'h0B);
    step(16'd10, 16'd0, 8'h00);
    step(16'd10, 16'd0, 8'h00);
    step(16'd10, 16'd10, 8'h00);
    step(16'd10, 16'd10, 8'h20);
  endtask

  task automatic s_still();
    cfg1(8'h04, 8'h04, 8'hB0);
    cfg2(8'h02, 8'h03, 16'h0003, 16'h000A);
    eng = 8'h04;
    step(16'd0, 16'd0, 8'h00);
    step(16'd1, 16'd0, 8'h00);
    step(16'hFFFD, 16'd0, 8'h40);
    chk1(pin2, 1'b1);
    chk1(pin1, 1'b0);
    step(16'd4, 16'd0, 8'h00);
  endtask

  task automatic s_gate();
    for (int i = 0; i < 3; i++) begin
      free_run = (i != 0);
      accel_on = (i != 1);
      eng = (i == 2) ? 8'h00 : 8'h04;
      repeat (4) step(16'd0, 16'd0, 8'h00);
    end
    free_run = 1'b1;
    accel_on = 1'b1;
    eng = 8'h04;
    repeat (2) step(16'd0, 16'd0, 8'h00);
    step(16'd0, 16'd0, 8'h40);
  endtask

  // The still engine runs too, as the significant detector depends on it.
  task automatic s_sig();
    cfg1(8'h04, 8'h02, 8'h11);
    cfg2(8'h00, 8'h06, 16'h0003, 16'h000A);
    eng = 8'h4E;
    step(16'd10, 16'd0, 8'h20);
    step(16'd0, 16'd0, 8'h00);
    step(16'd10, 16'd0, 8'h20);
    repeat (5) step(16'd0, 16'd0, 8'h00);
    repeat (7) step(16'd0, 16'd0, 8'h40);
    step(16'd10, 16'd0, 8'h20);
    repeat (3) step(16'd0, 16'd0, 8'h00);
    step(16'd10, 16'd0, 8'hA0);
    chk1(pin1, 1'b1);
    repeat (5) step(16'd0, 16'd0, 8'h80);
    step(16'd0, 16'd0, 8'h40);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    s_reset();
    s_config();
    s_any();
    s_and();
    s_still();
    s_gate();
    s_sig();
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    s_reset();
    close_out();
  end
endmodule
